/* hdl/sssr_host.sv */
// Purpose: Driver for eight recirculating shift registers as a memory
// Assumes: CLK_SYS at 20 MHz; one bit written per shift pulse
// Notes: Write bits queue in a FIFO; reads show the selected output
`default_nettype none
module sssr_host (
  input wire logic CLK_SYS,
  input wire logic SRST,
  sssr_if.host LINK,
  input wire logic RUN,
  input wire logic WR_EN_N,
  input wire logic [sssr_pkg::ADDR_W-1:0] WR_ADDR,
  input wire logic WR_VALID,
  output logic WR_READY,
  input wire logic WR_DATA,
  input wire logic [sssr_pkg::ADDR_W-1:0] RD_ADDR,
  output logic RD_DATA,
  output logic RD_STROBE
);
  typedef enum logic [2:0] {
    SSSR_IDLE = 3'b001,
    SSSR_HIGH = 3'b010,
    SSSR_LOW = 3'b100
  } sssr_state_t;
  function automatic logic [sssr_pkg::NUM_REGS-1:0] sssr_dec(
    input logic [sssr_pkg::ADDR_W-1:0] a
  );
    sssr_dec = '0;
    sssr_dec[a] = 1'b1;
  endfunction
  sssr_state_t state;
  logic [7:0] cnt;
  logic f_valid;
  logic f_data;
  logic f_pop;
  logic write_now;
  logic fifo_in_ready;
  logic wr_take;
  logic [sssr_pkg::NUM_REGS-1:0] dout_s1, dout_s2, dout_s3;
  // Write is only done while enabled and a bit is queued
  localparam logic [7:0] CNT_LAST = 8'(sssr_pkg::HALF_CYCLES - 1);
  assign write_now = !WR_EN_N && f_valid;
  assign f_pop = write_now && (state == SSSR_LOW) && (cnt == CNT_LAST);
  // Only a bit offered while the registered ready is high is taken
  assign wr_take = WR_VALID && WR_READY;
  sssr_fifo #(.WIDTH(sssr_pkg::FIFO_W), .DEPTH(sssr_pkg::FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .srst(SRST),
    .in_valid(wr_take),
    .in_ready(fifo_in_ready),
    .in_data(WR_DATA),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      WR_READY <= 1'b0;
    end else begin
      // Drop for a cycle after each take, so a lagging ready never offers a full FIFO
      WR_READY <= fifo_in_ready && !wr_take;
    end
  end
  // Clock pulses at fixed half period: high far below the 100 us limit
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state <= SSSR_IDLE;
      cnt <= sssr_pkg::CNT_RST;
      LINK.shift_clock <= 1'b0;
    end else begin
      case (state)
        SSSR_IDLE: begin
          if (RUN) begin
            state <= SSSR_HIGH;
            cnt <= sssr_pkg::CNT_RST;
            LINK.shift_clock <= 1'b1;
          end
        end
        SSSR_HIGH: begin
          if (cnt == CNT_LAST) begin
            state <= SSSR_LOW;
            cnt <= sssr_pkg::CNT_RST;
            LINK.shift_clock <= 1'b0;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        SSSR_LOW: begin
          if (cnt == CNT_LAST) begin
            cnt <= sssr_pkg::CNT_RST;
            state <= RUN ? SSSR_HIGH : SSSR_IDLE;
            LINK.shift_clock <= RUN;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          state <= SSSR_IDLE;
          LINK.shift_clock <= 1'b0;
        end
      endcase
    end
  end
  // Select and data1 update only while not in SSSR_HIGH, so they hold through the high phase and at the fall
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      LINK.sel <= '0;
      LINK.data1 <= '0;
    end else if (state != SSSR_HIGH) begin
      LINK.sel <= write_now ? sssr_dec(WR_ADDR) : '0;
      LINK.data1 <= {sssr_pkg::NUM_REGS{write_now && f_data}};
    end
  end
  // Recirculation path: each output looped to its own input zero
  always_ff @(posedge CLK_SYS) begin
    dout_s1 <= LINK.dout;
    dout_s2 <= dout_s1;
    dout_s3 <= dout_s2;
  end
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      LINK.data0 <= '0;
    end else if (dout_s2 == dout_s3) begin
      LINK.data0 <= dout_s3;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      RD_DATA <= 1'b0;
      RD_STROBE <= 1'b0;
    end else begin
      RD_DATA <= dout_s3[RD_ADDR];
      RD_STROBE <= (state == SSSR_LOW) && (cnt == CNT_LAST);
    end
  end
endmodule
`default_nettype wire

/* hdl/sssr_pkg.sv */
// Purpose: Shared constants for the 1024-stage shift register and its driver
// Assumes: CLK_SYS at 20 MHz
// Notes: Shift clock is generated by the driver end from CLK_SYS
`default_nettype none
package sssr_pkg;
  localparam int STAGES = 1024;
  localparam int SYS_CLK_HZ = 20000000;
  localparam int SHIFT_CLK_MAX_HZ = 2000000;
  localparam int HIGH_MAX_US = 100;
  // Half period of the driven shift clock, rounded up so 2.0 MHz is never passed
  localparam int HALF_CYCLES = (SYS_CLK_HZ + 2 * SHIFT_CLK_MAX_HZ - 1) / (2 * SHIFT_CLK_MAX_HZ);
  // Longest high time, rounded down
  localparam int HIGH_MAX_CYCLES = HIGH_MAX_US * (SYS_CLK_HZ / 1000000);
  localparam int NUM_REGS = 8;
  localparam int ADDR_W = 3;
  localparam int FIFO_W = 1;
  localparam int FIFO_DEPTH = 4;
  localparam logic [7:0] CNT_RST = 8'h00;
endpackage
`default_nettype wire

/* hdl/sssr_if.sv */
// Purpose: Pins between the driver logic and eight shift registers
// Assumes: One clock domain, CLK_SYS
// Notes: Registers are replicated per lane, index by register number
`default_nettype none
interface sssr_if;
  logic shift_clock;
  logic [sssr_pkg::NUM_REGS-1:0] sel;
  logic [sssr_pkg::NUM_REGS-1:0] data0;
  logic [sssr_pkg::NUM_REGS-1:0] data1;
  logic [sssr_pkg::NUM_REGS-1:0] dout;
  modport device (input shift_clock, input sel, input data0, input data1, output dout);
  modport host (output shift_clock, output sel, output data0, output data1, input dout);
endinterface
`default_nettype wire

/* hdl/sssr_fifo.sv */
// Purpose: Small valid/ready FIFO
// Assumes: Single clock, synchronous reset
// Notes: Full when DEPTH entries held
`default_nettype none
module sssr_fifo #(
  parameter int WIDTH = sssr_pkg::FIFO_W,
  parameter int DEPTH = sssr_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* hdl/sssr_device.sv */
// Purpose: Eight 1024-stage static shift registers with input select
// Assumes: Shift clock is a pin, sampled on CLK_SYS
// Notes: No reset of stored bits; contents unknown until 1024 shifts
`default_nettype none
module sssr_device (
  input wire logic CLK_SYS,
  input wire logic SRST,
  sssr_if.device LINK
);
  // Three-stage sampler; a change counts when stages two and three agree
  logic [2:0] clk_s;
  logic [sssr_pkg::NUM_REGS-1:0] sel_s1, sel_s2;
  logic [sssr_pkg::NUM_REGS-1:0] d0_s1, d0_s2;
  logic [sssr_pkg::NUM_REGS-1:0] d1_s1, d1_s2;
  logic clk_level;
  logic fall;
  always_ff @(posedge CLK_SYS) begin
    clk_s <= {clk_s[1:0], LINK.shift_clock};
    sel_s1 <= LINK.sel;
    sel_s2 <= sel_s1;
    d0_s1 <= LINK.data0;
    d0_s2 <= d0_s1;
    d1_s1 <= LINK.data1;
    d1_s2 <= d1_s1;
  end
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      clk_level <= 1'b0;
    end else if (clk_s[1] == clk_s[2]) begin
      clk_level <= clk_s[2];
    end
  end
  // Capture on high-to-low, with data sampled alongside the clock
  assign fall = clk_level && (clk_s[1] == clk_s[2]) && !clk_s[2];
  genvar g;
  generate
    for (g = 0; g < sssr_pkg::NUM_REGS; g++) begin : g_reg
      logic [sssr_pkg::STAGES-1:0] chain;
      logic in_bit;
      assign in_bit = sel_s2[g] ? d1_s2[g] : d0_s2[g];
      always_ff @(posedge CLK_SYS) begin
        if (fall) begin
          chain <= {chain[sssr_pkg::STAGES-2:0], in_bit};
        end
        // Otherwise held indefinitely
      end
      assign LINK.dout[g] = chain[sssr_pkg::STAGES-1];
    end
  endgenerate
endmodule
`default_nettype wire

/* tb/sssr_monitor.sv */
// Purpose: Pin-level checks between host and device ends
// Assumes: One CLK_SYS domain, reset SRST
// Notes: Stored bits may stay unknown, so no check compares them
`default_nettype none
module sssr_monitor (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic shift_clock,
  input wire logic [sssr_pkg::NUM_REGS-1:0] sel,
  input wire logic [sssr_pkg::NUM_REGS-1:0] data1,
  input wire logic [sssr_pkg::NUM_REGS-1:0] dout
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  clk_high_len_a: assert property ($rose(shift_clock) |=> shift_clock [*4] ##1 !shift_clock)
    else $error("shift clock high time wrong");
  clk_low_len_a: assert property ($fell(shift_clock) |-> !shift_clock [*5])
    else $error("shift clock low time short");
  clk_period_a: assert property ($rose(shift_clock) |=> !$rose(shift_clock) [*8] ##1 !$rose(shift_clock))
    else $error("shift clock too fast");
  high_stable_a: assert property (shift_clock && $past(shift_clock) |-> $stable({sel, data1}))
    else $error("input moved in high phase");
  fall_hold_a: assert property ($fell(shift_clock) |-> $stable(sel) && $stable(data1))
    else $error("input moved at falling edge");
  low_hold_a: assert property (!shift_clock [*8] |-> $stable(dout))
    else $error("output moved while clock stopped");
  sel_onehot_a: assert property ($onehot0(sel))
    else $error("more than one register written");
  // Shift must follow a falling edge, never the rising one
  dout_timing_a: assert property ($changed(dout) |-> !shift_clock &&
    ($past(shift_clock, 4) || $past(shift_clock, 5)))
    else $error("output moved outside shift window");
endmodule
`default_nettype wire

/* tb/test_static_serial_shift_register_1024.sv */
// Purpose: Memory test of registers 2 and 5 of the eight recirculating registers
// Assumes: 20 MHz clock, FIFO of 4 on the write stream
// Notes: Alternating data proves an even chain length
`default_nettype none
module test_static_serial_shift_register_1024;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 0, SRST = 1, RUN = 0, WR_EN_N = 1, WR_VALID = 0, WR_DATA = 0;
  logic [2:0] WR_ADDR = 3'h0, RD_ADDR = 3'h0;
  logic WR_READY, RD_DATA, RD_STROBE, prev;
  int failures = 0, samples_checked = 0;
  sssr_if link ();
  sssr_device sssr_device_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .LINK(link));
  sssr_host sssr_host_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .LINK(link), .RUN(RUN),
    .WR_EN_N(WR_EN_N), .WR_ADDR(WR_ADDR), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
    .WR_DATA(WR_DATA), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .RD_STROBE(RD_STROBE));
  sssr_monitor sssr_monitor_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .shift_clock(link.shift_clock),
    .sel(link.sel), .data1(link.data1), .dout(link.dout));
  always #25 CLK_SYS = ~CLK_SYS;
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  // Valid stays high between pushes so it is never driven twice in one step
  task automatic push(input logic d);
    WR_VALID = 1;
    WR_DATA = d;
    while (WR_READY !== 1'b1) @(negedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask
  // Sample two cycles after the strobe, clear of the next shift
  task automatic strobe(output logic v);
    int k;
    k = 0;
    while (RD_STROBE !== 1'b1 && k < 30) begin
      @(negedge CLK_SYS);
      k++;
    end
    repeat (2) @(negedge CLK_SYS);
    v = RD_DATA;
  endtask
  task automatic rot(input int cnt, input logic ones);
    logic v;
    strobe(prev);
    repeat (cnt) begin
      strobe(v);
      check("rd_data", ones ? 1'b1 : ~prev, v);
      prev = v;
    end
  endtask
  task automatic write_reg(input logic [2:0] a, input int cnt, input logic ones);
    WR_ADDR = a;
    WR_EN_N = 0;
    for (int i = 0; i < cnt; i++) begin
      if (i == 4 && RUN == 1'b0) begin
        repeat (20) @(negedge CLK_SYS);
        check("wr_ready", 1'b0, WR_READY);
        RUN = 1;
      end
      push(ones | i[0]);
    end
    WR_VALID = 0;
    repeat (60) @(negedge CLK_SYS);
    WR_EN_N = 1;
    RD_ADDR = a;
  endtask
  initial begin
    @(negedge CLK_SYS);
    check("wr_ready", 1'b0, WR_READY);
    @(negedge CLK_SYS);
    SRST = 0;
    write_reg(3'h2, 2048, 1'b0);
    rot(1030, 1'b0);
    write_reg(3'h5, 1100, 1'b1);
    rot(20, 1'b1);
    RD_ADDR = 3'h2;
    rot(1030, 1'b0);
    RUN = 0;
    repeat (20) @(negedge CLK_SYS);
    prev = RD_DATA;
    repeat (200) @(negedge CLK_SYS);
    check("held rd_data", prev, RD_DATA);
    RUN = 1;
    rot(4, 1'b0);
    conclude();
  end
  initial begin
    repeat (80000) @(posedge CLK_SYS);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
